// >>> lrb_defines.vh
`ifndef LRB_DEFINES_VH
`define LRB_DEFINES_VH

// ----------------------------------------------------------------
// bus address
// ----------------------------------------------------------------
// upper six bits of the target address byte, select pin fills bit 1
`define LRB_ADDR_HI 6'h1C
// position of the direction bit in the address byte
`define LRB_RW_BIT 0

// ----------------------------------------------------------------
// control byte fields
// ----------------------------------------------------------------
`define LRB_CO_BIT 7
`define LRB_RS_BIT 6

// ----------------------------------------------------------------
// bit counter landmarks
// ----------------------------------------------------------------
`define LRB_BITS_PER_BYTE 4'h8
`define LRB_ACK_SLOT 4'h9

// ----------------------------------------------------------------
// drive modes
// ----------------------------------------------------------------
`define LRB_MODE_STATIC 2'h0
`define LRB_MODE_MUX2 2'h1
`define LRB_MODE_MUX3 2'h2
`define LRB_MODE_MUX4 2'h3

// ----------------------------------------------------------------
// display ram geometry
// ----------------------------------------------------------------
`define LRB_RAM_DEPTH 160
`define LRB_RAM_AW 8
`define LRB_RAM_ROWS 4
`define LRB_RAM_LAST 8'h9F

`endif

// >>> lrb_ram.v
`timescale 1ns/1ps
`include "lrb_defines.vh"

// ----------------------------------------------------------------
// display ram, one column per address, row-masked writes
// ----------------------------------------------------------------
module lrb_ram #(
  parameter DEPTH = `LRB_RAM_DEPTH,
  parameter AW = `LRB_RAM_AW,
  parameter W = `LRB_RAM_ROWS
) (
  // clock
  input wire clk,
  // write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  input wire [W-1:0] wr_mask,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);

  reg [W-1:0] mem [0:DEPTH-1];

  // masked write keeps unselected rows, e.g. the other bank
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // registered read; addresses past the end read as zero
  always @(posedge clk) begin
    if (rd_addr < DEPTH) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= {W{1'b0}};
    end
  end

endmodule // lrb_ram

// >>> lrb_i2c_write_port.v
// Summary of operation
// - two-backplane mode with output bank 0 shows rows 0 and 1 alternately across the multiplex phases
// - static mode shows row 0 unless output bank 1 is chosen
// - input and output bank selectors are independent, both set by command
// - bank switching works only in static and two-backplane modes, banks 0 and 1
// - static mode with output bank 1 shows row 2 instead of row 0
// - two-backplane mode with output bank 1 shows rows 2 and 3
// - data fall with clock high is start, data rise with clock high is stop
// - each byte is followed by one acknowledge clock, any byte count per frame
// - acknowledge output held low through the acknowledge clock high time
// - receive only: never starts, never returns data, only acknowledges
// - answers only target addresses 0111 000 and 0111 001, msb first
// - address bit 1 compared with the target address select pin
// - read requests are not answered; direction bit should be 0
// - matching devices acknowledge address; others ignore until next start or stop
// - control byte flags mark next byte as command or display data, and whether a control byte follows it
// - control bytes acknowledged by every addressed device, command bytes only while the buffer has room
// - display bytes acknowledged only when subaddress counter matches the pins
// - display byte stored at data pointer and subaddress counter location
// - pointer advances eight, four, three or two per byte by drive mode
// - subaddress mismatch suppresses the write but still advances the pointer
// - pointer overflow past the last address increments the subaddress counter
// - four-backplane mode steps rows 0, 1, 2 and 3 across the multiplex phases
`timescale 1ns/1ps
`include "lrb_defines.vh"

module lrb_i2c_write_port #(
  parameter AW = `LRB_RAM_AW
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial bus pins
  input wire scl,
  input wire sda,
  output reg ack_output_pin_o,
  output reg ack_output_pin_oe,
  // strap pins
  input wire target_address_select_pin,
  input wire hw_subaddress_bit_low,
  input wire hw_subaddress_bit_high,
  // configuration from the command decoder
  input wire [1:0] drive_mode,
  input wire input_bank,
  input wire output_bank,
  input wire ptr_load,
  input wire [AW-1:0] ptr_value,
  input wire subaddr_load,
  input wire [1:0] subaddr_value,
  // command byte stream out
  output reg cmd_valid,
  output reg [7:0] cmd_byte,
  input wire cmd_ready,
  // display register read side
  input wire [AW-1:0] disp_addr,
  input wire [1:0] mux_phase,
  output reg disp_bit,
  // status
  output reg [AW-1:0] data_ptr,
  output reg [1:0] subaddr_cnt,
  output reg bus_busy
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // ram rows filled per column in each drive mode
  function [3:0] rows_per_col;
    input [1:0] mode;
    begin
      case (mode)
        `LRB_MODE_STATIC: rows_per_col = 4'h1;
        `LRB_MODE_MUX2: rows_per_col = 4'h2;
        `LRB_MODE_MUX3: rows_per_col = 4'h3;
        default: rows_per_col = 4'h4;
      endcase
    end
  endfunction

  // bank offset in rows; banks exist only in static and two-backplane
  function [1:0] bank_base;
    input [1:0] mode;
    input bank;
    begin
      if ((mode == `LRB_MODE_STATIC) || (mode == `LRB_MODE_MUX2)) begin
        bank_base = {bank, 1'b0};
      end else begin
        bank_base = 2'h0;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam NSYNC = 5;
  wire [NSYNC-1:0] pin_raw;
  wire [NSYNC-1:0] pin_s;
  assign pin_raw = {hw_subaddress_bit_high, hw_subaddress_bit_low,
                    target_address_select_pin, sda, scl};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // each lane owns its own pair, so no vector has several drivers
      reg m_r;
      reg s_r;
      // two flops per pin; the first feeds only the second
      always @(posedge clk) begin
        if (!rst_n) begin
          m_r <= 1'b1;
          s_r <= 1'b1;
        end else begin
          m_r <= pin_raw[gi];
          s_r <= m_r;
        end
      end
      assign pin_s[gi] = s_r;
    end
  endgenerate

  wire scl_s = pin_s[0];
  wire sda_s = pin_s[1];
  wire sa_sel_s = pin_s[2];
  wire [1:0] hw_sub_s = pin_s[4:3];

  // previous levels for edge detection
  reg scl_d_r;
  reg sda_d_r;
  always @(posedge clk) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // data moving while clock stays high is a bus condition
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------------------------------
  // command buffer, two entries
  // ----------------------------------------------------------------
  reg spare_v_r;
  reg [7:0] spare_d_r;
  wire buf_ready = ~spare_v_r;
  reg push;
  reg [7:0] push_data;
  wire pop = cmd_valid & cmd_ready;

  // head sits in the output flops, second word in the spare
  always @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      spare_v_r <= 1'b0;
      spare_d_r <= 8'h00;
    end else if (pop) begin
      if (spare_v_r) begin
        cmd_byte <= spare_d_r;
        spare_v_r <= 1'b0;
      end else begin
        cmd_valid <= push;
        cmd_byte <= push_data;
      end
    end else if (push) begin
      if (!cmd_valid) begin
        cmd_valid <= 1'b1;
        cmd_byte <= push_data;
      end else begin
        spare_v_r <= 1'b1;
        spare_d_r <= push_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_BYTE = 2'h2;
  localparam ST_SKIP = 2'h3;

  reg [1:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg expect_ctrl_r;
  reg last_ctrl_r;
  reg rs_r;
  reg disp_go;

  wire [7:0] rx_byte = shift_r;
  wire addr_hit = (rx_byte[7:2] == `LRB_ADDR_HI) && (rx_byte[1] == sa_sel_s);
  wire sub_match = (subaddr_cnt == hw_sub_s);

  // byte handling at the falling clock that closes bit 8
  always @* begin
    push = 1'b0;
    push_data = rx_byte;
    disp_go = 1'b0;
    if (scl_fall && (bit_cnt_r == `LRB_BITS_PER_BYTE) && (state_r == ST_BYTE) &&
        !expect_ctrl_r) begin
      if (rs_r) begin
        disp_go = 1'b1;
      end else begin
        push = buf_ready;
      end
    end
  end

  // shifting, acknowledge slot and byte classification
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      expect_ctrl_r <= 1'b1;
      last_ctrl_r <= 1'b0;
      rs_r <= 1'b0;
      ack_output_pin_o <= 1'b0;
      ack_output_pin_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else if (start_det) begin
      // also a repeated start: every frame opens with an address
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      expect_ctrl_r <= 1'b1;
      last_ctrl_r <= 1'b0;
      ack_output_pin_oe <= 1'b0;
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      ack_output_pin_oe <= 1'b0;
      bus_busy <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise && (bit_cnt_r < `LRB_BITS_PER_BYTE)) begin
        shift_r <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && (bit_cnt_r == `LRB_BITS_PER_BYTE)) begin
        bit_cnt_r <= `LRB_ACK_SLOT;
        case (state_r)
          ST_ADDR: begin
            // a read request is never answered, nor anything after it
            if (addr_hit && !rx_byte[`LRB_RW_BIT]) begin
              state_r <= ST_BYTE;
              ack_output_pin_oe <= 1'b1;
            end else begin
              state_r <= ST_SKIP;
            end
          end
          ST_BYTE: begin
            if (expect_ctrl_r) begin
              rs_r <= rx_byte[`LRB_RS_BIT];
              last_ctrl_r <= ~rx_byte[`LRB_CO_BIT];
              expect_ctrl_r <= 1'b0;
              ack_output_pin_oe <= 1'b1;
            end else begin
              // after a final control byte the stream never returns to control
              expect_ctrl_r <= ~last_ctrl_r;
              if (rs_r) begin
                ack_output_pin_oe <= sub_match;
              end else begin
                // a full buffer refuses the byte by withholding the ack
                ack_output_pin_oe <= buf_ready;
              end
            end
          end
          default: begin
            ack_output_pin_oe <= 1'b0;
          end
        endcase
      end else if (scl_fall && (bit_cnt_r == `LRB_ACK_SLOT)) begin
        // released only after the clock high time of the ack slot
        ack_output_pin_oe <= 1'b0;
        bit_cnt_r <= 4'h0;
      end
    end
    // open drain: the level is always low, only the enable moves
    ack_output_pin_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // display ram write engine
  // ----------------------------------------------------------------
  reg wr_busy_r;
  reg [7:0] wr_sh_r;
  reg [3:0] wr_rem_r;
  reg [1:0] wr_mode_r;
  reg [1:0] wr_base_r;

  wire [3:0] n_rows = rows_per_col(wr_mode_r);
  // last column in three-backplane mode gets only two bits
  wire [3:0] n_eff = (wr_rem_r < n_rows) ? wr_rem_r : n_rows;
  wire [3:0] bits_rev = {wr_sh_r[4], wr_sh_r[5], wr_sh_r[6], wr_sh_r[7]};
  wire [7:0] mask_full = (8'h01 << n_eff) - 8'h01;
  wire [7:0] mask_sh = {mask_full[3:0], 4'h0} >> (3'h4 - {1'b0, wr_base_r});
  wire [7:0] data_sh = {bits_rev, 4'h0} >> (3'h4 - {1'b0, wr_base_r});
  wire [3:0] wr_mask = mask_sh[7:4] & mask_full[7:4] | mask_sh[3:0] & 4'hF & mask_sh[3:0];
  wire [3:0] wr_data = data_sh[3:0] | data_sh[7:4];
  wire ram_we = wr_busy_r & sub_match;
  wire [3:0] rem_nxt = wr_rem_r - n_eff;

  // column steps; one column per clock, far faster than the bus
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_busy_r <= 1'b0;
      wr_sh_r <= 8'h00;
      wr_rem_r <= 4'h0;
      wr_mode_r <= `LRB_MODE_STATIC;
      wr_base_r <= 2'h0;
    end else if (disp_go) begin
      wr_busy_r <= 1'b1;
      wr_sh_r <= rx_byte;
      wr_rem_r <= `LRB_BITS_PER_BYTE;
      wr_mode_r <= drive_mode;
      wr_base_r <= bank_base(drive_mode, input_bank);
    end else if (wr_busy_r) begin
      wr_sh_r <= wr_sh_r << n_eff;
      wr_rem_r <= rem_nxt;
      wr_busy_r <= (rem_nxt != 4'h0);
    end
  end

  // pointer moves one column per step: 8, 4, 3 or 2 per byte
  always @(posedge clk) begin
    if (!rst_n) begin
      data_ptr <= {AW{1'b0}};
      subaddr_cnt <= 2'h0;
    end else begin
      if (ptr_load) begin
        data_ptr <= ptr_value;
      end else if (wr_busy_r) begin
        if (data_ptr == `LRB_RAM_LAST) begin
          data_ptr <= {AW{1'b0}};
        end else begin
          data_ptr <= data_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      if (subaddr_load) begin
        subaddr_cnt <= subaddr_value;
      end else if (wr_busy_r && (data_ptr == `LRB_RAM_LAST)) begin
        subaddr_cnt <= subaddr_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // display ram and output bank selector
  // ----------------------------------------------------------------
  wire [3:0] rd_col;
  reg [1:0] row_r;
  reg [1:0] row_nxt;

  lrb_ram #(
    .DEPTH(`LRB_RAM_DEPTH),
    .AW(AW),
    .W(`LRB_RAM_ROWS)
  ) u_ram (
    .clk(clk),
    .wr_en(ram_we),
    .wr_addr(data_ptr),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .rd_addr(disp_addr),
    .rd_data(rd_col)
  );

  // row for the current multiplex phase
  always @* begin
    case (drive_mode)
      `LRB_MODE_STATIC: row_nxt = bank_base(drive_mode, output_bank);
      `LRB_MODE_MUX2: row_nxt = bank_base(drive_mode, output_bank) | {1'b0, mux_phase[0]};
      `LRB_MODE_MUX3: row_nxt = (mux_phase == 2'h3) ? 2'h0 : mux_phase;
      default: row_nxt = mux_phase;
    endcase
  end

  // row choice travels alongside the registered ram read
  always @(posedge clk) begin
    if (!rst_n) begin
      row_r <= 2'h0;
      disp_bit <= 1'b0;
    end else begin
      row_r <= row_nxt;
      disp_bit <= rd_col[row_r];
    end
  end

endmodule // lrb_i2c_write_port

// >>> lrb_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// serial bus master model, 64 ns bit clock
// ----------------------------------------
module lrb_master_model (
  // bus lines
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // both lines idle high, clock stands still outside frames
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  // start or repeated start: data falls while clock high
  task automatic start();
    #8 sda_m = 1'h1;
    #24 scl = 1'h1;
    #32 sda_m = 1'h0;
    #32 scl = 1'h0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #8 sda_m = 1'h0;
    #24 scl = 1'h1;
    #32 sda_m = 1'h1;
    #32;
  endtask
  // data moves only in clock low, so no false start or stop
  task automatic put(input logic [7:0] b, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      #8 sda_m = b[i];
      #24 scl = 1'h1;
      #32 scl = 1'h0;
    end
    #8 sda_m = 1'h1;
    #24 scl = 1'h1;
    #16 ak = sda;
    #16 scl = 1'h0;
  endtask
endmodule // lrb_master_model

// >>> lrb_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the write port
// ----------------------------------------
module lrb_checker #(
  parameter AW = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bus side
  input wire scl,
  input wire ack_output_pin_o,
  input wire ack_output_pin_oe,
  input wire bus_busy,
  // command stream
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire cmd_ready,
  // display read and counters
  input wire [AW-1:0] disp_addr,
  input wire disp_bit,
  input wire ptr_load,
  input wire subaddr_load,
  input wire [AW-1:0] data_ptr,
  input wire [1:0] subaddr_cnt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ack pin only ever pulls low
  chk_ack_drv_zero: assert property (ack_output_pin_o == 1'h0)
    else $error("ack data not low");
  chk_ack_in_frame: assert property (ack_output_pin_oe |-> bus_busy)
    else $error("ack outside frame");
  // edges of ack land in clock low so the high phase sees it stable
  chk_ack_clk_low: assert property ($changed(ack_output_pin_oe) |-> !scl)
    else $error("ack moved with clock high");
  chk_ack_hold: assert property (ack_output_pin_oe && $rose(scl) |-> ack_output_pin_oe [*6])
    else $error("ack dropped in clock high");
  chk_cmd_hold_on: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
    else $error("command byte not held");
  chk_disp_range: assert property ($past(rst_n, 2) && $past(disp_addr, 2) > 8'h9F |-> !disp_bit)
    else $error("read past ram end");
  // pointer moves one column at a time, wraps to zero
  chk_ptr_step: assert property (!$past(ptr_load) && data_ptr != $past(data_ptr)
    |-> bus_busy && (data_ptr == $past(data_ptr) + 8'h01 || data_ptr == 8'h00))
    else $error("bad pointer step");
  chk_sub_wrap: assert property (!$past(subaddr_load) && subaddr_cnt != $past(subaddr_cnt)
    |-> subaddr_cnt == $past(subaddr_cnt) + 2'h1 && $past(data_ptr) == 8'h9F)
    else $error("subaddress moved without wrap");
  cov_ack: cover property ($rose(ack_output_pin_oe));
  cov_pop: cover property (cmd_valid && cmd_ready);
  cov_wrap: cover property (!$past(subaddr_load) && subaddr_cnt != $past(subaddr_cnt));
endmodule // lrb_checker

bind lrb_i2c_write_port lrb_checker #(.AW(AW)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl(scl), .ack_output_pin_o(ack_output_pin_o),
  .ack_output_pin_oe(ack_output_pin_oe), .bus_busy(bus_busy), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .disp_addr(disp_addr), .disp_bit(disp_bit),
  .ptr_load(ptr_load), .subaddr_load(subaddr_load), .data_ptr(data_ptr),
  .subaddr_cnt(subaddr_cnt)
);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // clock, pins and counters
  // ----------------------------------------
  logic clk, rst_n, sel, sa_lo, sa_hi, ib, ob, pl, sl, cr;
  logic [1:0] md, sv, ph;
  logic [7:0] pv, da;
  logic [31:0] seed;
  wire scl, sda_m, sda, ao, aoe, cv, db, busy;
  wire [7:0] cb, dp;
  wire [1:0] sc;
  int failures, checks;
  // open-drain line with pull-up
  assign sda = sda_m & ~(aoe & ~ao);
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  lrb_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));
  lrb_i2c_write_port dut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda(sda), .ack_output_pin_o(ao),
    .ack_output_pin_oe(aoe), .target_address_select_pin(sel),
    .hw_subaddress_bit_low(sa_lo), .hw_subaddress_bit_high(sa_hi), .drive_mode(md),
    .input_bank(ib), .output_bank(ob), .ptr_load(pl), .ptr_value(pv),
    .subaddr_load(sl), .subaddr_value(sv), .cmd_valid(cv), .cmd_byte(cb),
    .cmd_ready(cr), .disp_addr(da), .mux_phase(ph), .disp_bit(db), .data_ptr(dp),
    .subaddr_cnt(sc), .bus_busy(busy)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one frame of n bytes, ak bit i low when byte i was acknowledged
  task automatic xfer(input logic [39:0] bs, input int n, output logic [4:0] ak);
    logic a;
    ak = 5'h1F;
    m.start();
    cmp(busy, 1'h1);
    for (int i = 0; i < n; i++) begin
      m.put(bs[39-8*i -: 8], a);
      ak[i] = a;
    end
    m.stop();
    cmp(busy, 1'h0);
  endtask
  task automatic ld(input logic [7:0] p, input logic [1:0] s);
    @(negedge clk);
    pl = 1'h1;
    sl = 1'h1;
    pv = p;
    sv = s;
    @(negedge clk);
    pl = 1'h0;
    sl = 1'h0;
  endtask
  // read answer stands two cycles after the request
  task automatic rd(input logic [7:0] a, input logic [1:0] p, input logic e);
    @(negedge clk);
    da = a;
    ph = p;
    repeat (2) @(negedge clk);
    cmp(db, e);
  endtask
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, about five times the expected run
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [4:0] ak;
    logic [7:0] p;
    int w, n;
    seed = 32'h15DC5;
    failures = 0;
    checks = 0;
    rst_n = 1'h0;
    {sel, sa_lo, sa_hi, ib, ob, pl, sl, cr} = 8'h00;
    {md, sv, ph, pv, da} = 22'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    repeat (6) @(negedge clk);
    // own address, other select level, read request
    for (int s = 0; s < 2; s++) begin
      @(negedge clk) sel = s[0];
      xfer({6'h1C, sel, 1'h0, 8'h80, 24'h0}, 2, ak);
      cmp(ak[1:0], 2'h0);
      xfer({6'h1C, ~sel, 1'h0, 8'h00, 24'h0}, 2, ak);
      cmp(ak[1:0], 2'h3);
      xfer({6'h1C, sel, 1'h1, 8'h00, 24'h0}, 2, ak);
      cmp(ak[1:0], 2'h3);
    end
    // stalled command stream: third byte refused, order kept
    r = rnd();
    xfer({6'h1C, sel, 1'h0, 8'h00, r[23:0]}, 5, ak);
    cmp(ak, 5'h10);
    for (int k = 0; k < 2; k++) begin
      cmp(cv, 1'h1);
      cmp(cb, r[23-8*k -: 8]);
      @(negedge clk) cr = 1'h1;
      @(negedge clk) cr = 1'h0;
      repeat (2) @(negedge clk);
    end
    cmp(cv, 1'h0);
    // display bytes in every mode, write bank differs from shown bank
    cr = 1'h1;
    for (int it = 0; it < 8; it++) begin
      r = rnd();
      @(negedge clk);
      md = it[1:0];
      // both bank settings in every mode; bank 1 is reached only in static and two-backplane
      ib = it[2];
      ob = ~it[2];
      w = md + 1;
      n = (md == 2'h2) ? 3 : 8 / w;
      p = r[31:24] % 8'h96;
      ld(p, 2'h0);
      xfer({6'h1C, sel, 1'h0, 8'h80, r[23:16], 8'hC0, r[7:0]}, 5, ak);
      cmp(ak, 5'h00);
      cmp(dp, 8'(p + n));
      @(negedge clk) ob = ib;
      for (int k = 0; k < n; k++)
        for (int q = 0; q < w && 7 - w*k - q >= 0; q++)
          rd(8'(p + k), 2'(q), r[7 - w*k - q]);
      rd(8'hA0 + {3'h0, r[12:8]}, 2'h0, 1'h0);
    end
    // strap mismatch: no ack, no write, pointer wraps into next device
    @(negedge clk) md = 2'h3;
    ld(8'h9E, 2'h1);
    xfer({6'h1C, sel, 1'h0, 8'h40, r[7:0], 16'h0}, 3, ak);
    cmp(ak[2:0], 3'h4);
    cmp(dp, 8'h00);
    cmp(sc, 2'h2);
    @(negedge clk) sa_hi = 1'h1;
    xfer({6'h1C, sel, 1'h0, 8'h40, r[15:8], 16'h0}, 3, ak);
    cmp(ak[2:0], 3'h0);
    rd(8'h01, 2'h3, r[8]);
    give_verdict();
  end
endmodule // testbench
